// ### design/wdf_downcounter.sv
// Loadable down-counter that holds at zero and holds while disabled.
`timescale 1ns/100ps
module wdf_downcounter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic countEn,
  // Count
  output logic [WIDTH-1:0] count_r
);
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = loadValue;
    end else if (countEn && (count_r != '0)) begin
      count_nxt = count_r - WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule : wdf_downcounter

// ### design/wdf_pkg.sv
// Package with register map, field positions, reset values and states of the watchdog fail-safe block.
package wdf_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_KICK = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;

  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_ACT_HALT_MAIN = 1;
  localparam int CTRL_ACT_HALT_COPROC = 2;
  localparam int CTRL_ACT_FAILSAFE_LOW = 3;
  localparam int CTRL_ACT_OUTPUTS_LOW = 4;
  localparam int CTRL_STANDBY_LEVEL = 5;
  localparam int CTRL_WIDTH = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields.
  localparam int STAT_EXPIRED = 0;
  localparam int STAT_ENABLED = 1;

  // Interrupt event fields.
  localparam int EVT_EXPIRY = 0;
  localparam int EVT_KICK = 1;
  localparam int EVT_WIDTH = 2;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // Stored starting value after reset; the count itself leaves reset at zero.
  localparam logic [31:0] RELOAD_RESET = 32'h0098_9680;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_TRIPPED = 3'b100
  } wdf_state_t;
endpackage : wdf_pkg

// ### design/wdf_watchdog.sv
// Watchdog fail-safe supervisor with register port, selectable expiry actions and interrupt.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// - Enabled counter decrements every clock in the run state; disabled counter holds its value.
// - Count reaching zero while enabled trips the fail-safe response immediately.
// - Only actions selected beforehand are performed; each has its own enable.
// - Selectable halt of main processor, separately selectable halt of coprocessor.
// - Selectable forcing of the fail-safe output pin low.
// - Selectable forcing of all general and numbered output channels low.
// - Fail-safe output pin is low after power-up.
// - While disabled the fail-safe pin follows the software standby level.
module wdf_watchdog #(
  parameter int CNT_WIDTH = 32,
  parameter int GEN_WIDTH = 32,
  parameter int NUM_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData_r,
  // Interrupt
  output logic irq_r,
  // Output channels from the rest of the system
  input wire logic [GEN_WIDTH-1:0] generalDigitalChannelsIn,
  input wire logic [NUM_WIDTH-1:0] numberedOutputChannelsIn,
  // Gated output channels toward the pins
  output logic [GEN_WIDTH-1:0] generalDigitalChannels_r,
  output logic [NUM_WIDTH-1:0] numberedOutputChannels_r,
  // Fail-safe actions
  output logic failsafeOut_r,
  output logic haltMain_r,
  output logic haltCoproc_r
);
  logic [wdf_pkg::CTRL_WIDTH-1:0] ctrl_r;
  logic [wdf_pkg::CTRL_WIDTH-1:0] ctrl_nxt;
  logic [CNT_WIDTH-1:0] reload_r;
  logic [CNT_WIDTH-1:0] reload_nxt;
  logic [wdf_pkg::EVT_WIDTH-1:0] intStatus_r;
  logic [wdf_pkg::EVT_WIDTH-1:0] intStatus_nxt;
  logic [wdf_pkg::EVT_WIDTH-1:0] intMask_r;
  logic [wdf_pkg::EVT_WIDTH-1:0] intMask_nxt;
  logic [31:0] regRdData_nxt;
  logic irq_nxt;

  wdf_pkg::wdf_state_t state_r;
  wdf_pkg::wdf_state_t state_nxt;
  logic expired_r;
  logic expired_nxt;
  logic [3:0] actions_r;
  logic [3:0] actions_nxt;

  logic failsafeOut_nxt;
  logic haltMain_nxt;
  logic haltCoproc_nxt;
  logic [GEN_WIDTH-1:0] generalDigitalChannels_nxt;
  logic [NUM_WIDTH-1:0] numberedOutputChannels_nxt;

  logic [CNT_WIDTH-1:0] count;
  logic enabled;
  logic initWrite;
  logic kickWrite;
  logic loadCounter;
  logic expiryEvent;
  logic [wdf_pkg::EVT_WIDTH-1:0] events;
  logic forceLow;
  logic [GEN_WIDTH-1:0] generalGated;
  logic [NUM_WIDTH-1:0] numberedGated;

  function automatic logic isWrite(input logic [7:0] addr, input logic wr, input logic [7:0] target);
    isWrite = wr && (addr == target);
  endfunction : isWrite

  function automatic logic isRead(input logic [7:0] addr, input logic rd, input logic [7:0] target);
    isRead = rd && (addr == target);
  endfunction : isRead

  assign enabled = ctrl_r[wdf_pkg::CTRL_ENABLE];
  // Writing the starting value is the initialization: it reloads and clears the expired state.
  assign initWrite = isWrite(regAddr, regWr, wdf_pkg::ADDR_RELOAD);
  assign kickWrite = isWrite(regAddr, regWr, wdf_pkg::ADDR_KICK);
  assign loadCounter = initWrite || kickWrite;

  // The count leaves reset at zero, so enabling before the first initialization trips at once.
  // This was preferred to a long default period because a missing initialization then shows up
  // immediately instead of after a long wait; software must write the starting value first.
  wdf_downcounter #(
    .WIDTH(CNT_WIDTH)
  ) u_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(loadCounter),
    .loadValue(initWrite ? regWrData[CNT_WIDTH-1:0] : reload_r),
    // Counting only in the run state keeps the count frozen after a trip for software to read.
    .countEn(enabled && (state_r == wdf_pkg::ST_RUN)),
    .count_r(count)
  );

  // Register file.
  // Control holds the enable, the four expiry actions and the standby level of the fail-safe pin.
  // A write of the starting value doubles as the initialization: it loads the count and ends a trip.
  // A kick reloads the count from the stored starting value and ignores its data, so a stray kick
  // cannot lengthen the period. Writes to read-only or unmapped offsets are dropped.
  always_comb begin
    ctrl_nxt = ctrl_r;
    reload_nxt = reload_r;
    intMask_nxt = intMask_r;
    // A control write is taken whole; the actions are only sampled at expiry, so a later change
    // has no effect on the halts and channel forcing of a trip in progress; clearing the enable hands the pin to the standby level.
    if (isWrite(regAddr, regWr, wdf_pkg::ADDR_CTRL)) begin
      ctrl_nxt = regWrData[wdf_pkg::CTRL_WIDTH-1:0];
    end
    if (initWrite) begin
      reload_nxt = regWrData[CNT_WIDTH-1:0];
    end
    if (isWrite(regAddr, regWr, wdf_pkg::ADDR_INT_MASK)) begin
      intMask_nxt = regWrData[wdf_pkg::EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= wdf_pkg::CTRL_RESET;
      // The default starting value only matters if software kicks without initializing first.
      reload_r <= wdf_pkg::RELOAD_RESET[CNT_WIDTH-1:0];
      intMask_r <= wdf_pkg::EVT_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      reload_r <= reload_nxt;
      intMask_r <= intMask_nxt;
    end
  end

  // Supervision state machine.
  // Idle: counter stopped. Run: counting down and supervising. Tripped: actions held until initialization.
  // Disabling while running parks the count where it is, so enabling again resumes the same period.
  // A zero count trips only while running; a kick after the trip reloads the count but the
  // trip itself is held until software initializes again, so a late kick cannot hide a fault.
  assign expiryEvent = (state_r == wdf_pkg::ST_RUN) && enabled && (count == '0);

  always_comb begin
    state_nxt = state_r;
    expired_nxt = expired_r;
    actions_nxt = actions_r;
    case (state_r)
      wdf_pkg::ST_IDLE: begin
        if (enabled) begin
          state_nxt = wdf_pkg::ST_RUN;
        end
      end
      wdf_pkg::ST_RUN: begin
        if (expiryEvent) begin
          state_nxt = wdf_pkg::ST_TRIPPED;
          expired_nxt = 1'b1;
          actions_nxt = ctrl_r[wdf_pkg::CTRL_ACT_OUTPUTS_LOW:wdf_pkg::CTRL_ACT_HALT_MAIN];
        end else if (!enabled) begin
          state_nxt = wdf_pkg::ST_IDLE;
        end
      end
      // Only the initialization leaves this state; disabling alone keeps the halts and channel forcing.
      wdf_pkg::ST_TRIPPED: begin
        if (initWrite) begin
          state_nxt = wdf_pkg::ST_IDLE;
          expired_nxt = 1'b0;
          actions_nxt = 4'h0;
        end
      end
      // An illegal code falls back to idle with the actions dropped; the next expiry sets them again.
      default: begin
        state_nxt = wdf_pkg::ST_IDLE;
        expired_nxt = 1'b0;
        actions_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= wdf_pkg::ST_IDLE;
      expired_r <= 1'b0;
      actions_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      expired_r <= expired_nxt;
      actions_r <= actions_nxt;
    end
  end

  // Each channel has its own gate, so the general and numbered groups may be sized independently.
  assign forceLow = actions_nxt[wdf_pkg::CTRL_ACT_OUTPUTS_LOW - 1];
  for (genvar g = 0; g < GEN_WIDTH; g++) begin : gen_general_gate
    assign generalGated[g] = generalDigitalChannelsIn[g] && !forceLow;
  end
  for (genvar g = 0; g < NUM_WIDTH; g++) begin : gen_numbered_gate
    assign numberedGated[g] = numberedOutputChannelsIn[g] && !forceLow;
  end

  // Fail-safe outputs, computed from the next state so that the response lands in the
  // same edge that records the expiry.
  // While disabled the pin is a plain software-driven output; on enable the watchdog takes it
  // over and holds it high until an expiry with the pin action selected drives it low.
  always_comb begin
    haltMain_nxt = actions_nxt[wdf_pkg::CTRL_ACT_HALT_MAIN - 1];
    haltCoproc_nxt = actions_nxt[wdf_pkg::CTRL_ACT_HALT_COPROC - 1];
    if (!ctrl_nxt[wdf_pkg::CTRL_ENABLE]) begin
      failsafeOut_nxt = ctrl_nxt[wdf_pkg::CTRL_STANDBY_LEVEL];
    end else if (actions_nxt[wdf_pkg::CTRL_ACT_FAILSAFE_LOW - 1]) begin
      failsafeOut_nxt = 1'b0;
    end else begin
      failsafeOut_nxt = 1'b1;
    end
    generalDigitalChannels_nxt = generalGated;
    numberedOutputChannels_nxt = numberedGated;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Channels stay low in reset too, matching what the equipment sees while the pin is low.
      failsafeOut_r <= 1'b0;
      haltMain_r <= 1'b0;
      haltCoproc_r <= 1'b0;
      generalDigitalChannels_r <= '0;
      numberedOutputChannels_r <= '0;
    end else begin
      failsafeOut_r <= failsafeOut_nxt;
      haltMain_r <= haltMain_nxt;
      haltCoproc_r <= haltCoproc_nxt;
      generalDigitalChannels_r <= generalDigitalChannels_nxt;
      numberedOutputChannels_r <= numberedOutputChannels_nxt;
    end
  end

  // Interrupt status: sticky events, cleared by reading, with a new event winning over the clear.
  // The kick event lets software confirm that its service routine really reaches the block.
  always_comb begin
    events = '0;
    events[wdf_pkg::EVT_EXPIRY] = expiryEvent;
    events[wdf_pkg::EVT_KICK] = kickWrite;
    intStatus_nxt = intStatus_r;
    if (isRead(regAddr, regRd, wdf_pkg::ADDR_INT_STATUS)) begin
      intStatus_nxt = '0;
    end
    intStatus_nxt = intStatus_nxt | events;
    irq_nxt = |(intStatus_nxt & intMask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intStatus_r <= wdf_pkg::EVT_RESET;
      irq_r <= 1'b0;
    end else begin
      intStatus_r <= intStatus_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Read data, valid in the cycle after the read strobe only; unmapped addresses read zero.
  // Returning zero outside the read cycle keeps the bus quiet, so an OR-combined read bus needs no mux.
  always_comb begin
    regRdData_nxt = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        wdf_pkg::ADDR_CTRL: begin
          regRdData_nxt[wdf_pkg::CTRL_WIDTH-1:0] = ctrl_r;
        end
        wdf_pkg::ADDR_RELOAD: begin
          regRdData_nxt[CNT_WIDTH-1:0] = reload_r;
        end
        wdf_pkg::ADDR_COUNT: begin
          regRdData_nxt[CNT_WIDTH-1:0] = count;
        end
        wdf_pkg::ADDR_STATUS: begin
          regRdData_nxt[wdf_pkg::STAT_EXPIRED] = expired_r;
          regRdData_nxt[wdf_pkg::STAT_ENABLED] = enabled;
        end
        wdf_pkg::ADDR_INT_STATUS: begin
          regRdData_nxt[wdf_pkg::EVT_WIDTH-1:0] = intStatus_r;
        end
        wdf_pkg::ADDR_INT_MASK: begin
          regRdData_nxt[wdf_pkg::EVT_WIDTH-1:0] = intMask_r;
        end
        default: begin
          regRdData_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData_r <= 32'h0000_0000;
    end else begin
      regRdData_r <= regRdData_nxt;
    end
  end
endmodule : wdf_watchdog

// ### tb/test_watchdog_failsafe.sv
// Self-checking testbench for the watchdog fail-safe block.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_watchdog_failsafe;
  logic ref_clk;
  logic rst;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWr;
  logic regRd;
  logic [31:0] rdData;
  logic irq_r;
  logic [31:0] genIn;
  logic [7:0] numIn;
  logic [31:0] genOut;
  logic [7:0] numOut;
  logic failsafeOut_r;
  logic haltMain_r;
  logic haltCoproc_r;
  logic safeMode_r;
  logic [31:0] d;
  logic [31:0] c1;
  int failures;
  int comparisons;

  wdf_watchdog i_wdf_watchdog (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_r(rdData), .irq_r(irq_r), .generalDigitalChannelsIn(genIn),
    .numberedOutputChannelsIn(numIn), .generalDigitalChannels_r(genOut), .numberedOutputChannels_r(numOut),
    .failsafeOut_r(failsafeOut_r), .haltMain_r(haltMain_r), .haltCoproc_r(haltCoproc_r));
  wdf_safe_equip i_wdf_safe_equip (.ref_clk(ref_clk), .failsafeOut(failsafeOut_r), .safeMode_r(safeMode_r));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = rdData;
  endtask : rd

  task automatic waitHalt();
    for (int i = 0; i < 40 && haltMain_r !== 1'b1; i++) @(negedge ref_clk);
    if (haltMain_r !== 1'b1) begin
      failures++;
      test_done();
    end
    @(negedge ref_clk);
  endtask : waitHalt

  task automatic tReset();
    `CHK({failsafeOut_r, haltMain_r, haltCoproc_r, irq_r}, 4'h0)
    `CHK({genOut, numOut}, {genIn, numIn})
    rd(wdf_pkg::ADDR_CTRL);
    `CHK(d, 32'h0000_0000)
    rd(8'h40);
    `CHK(d, 32'h0000_0000)
    $display("reset test done");
  endtask : tReset

  task automatic tStandby();
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0020);
    `CHK(failsafeOut_r, 1'b1)
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(failsafeOut_r, 1'b0)
    $display("standby test done");
  endtask : tStandby

  // Two back-to-back count reads are two cycles apart, so the count must drop by exactly two.
  task automatic tKick();
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0040);
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_001F);
    rd(wdf_pkg::ADDR_COUNT);
    c1 = d;
    rd(wdf_pkg::ADDR_COUNT);
    `CHK(c1 - d, 32'h0000_0002)
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0006);
    for (int k = 0; k < 10; k++) wr(wdf_pkg::ADDR_KICK, 32'h0000_0000);
    `CHK({haltMain_r, failsafeOut_r}, 2'h1)
    rd(wdf_pkg::ADDR_INT_STATUS);
    `CHK(d, 32'h0000_0002)
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(wdf_pkg::ADDR_COUNT);
    c1 = d;
    rd(wdf_pkg::ADDR_COUNT);
    `CHK(d, c1)
    rd(wdf_pkg::ADDR_RELOAD);
    `CHK(d, 32'h0000_0006)
    $display("kick test done");
  endtask : tKick

  task automatic tSelect();
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0003);
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0003);
    waitHalt();
    `CHK({haltCoproc_r, failsafeOut_r, irq_r}, 3'h2)
    `CHK({genOut, numOut}, {genIn, numIn})
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0100);
    `CHK(haltMain_r, 1'b0)
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("select test done");
  endtask : tSelect

  task automatic tFull();
    rd(wdf_pkg::ADDR_INT_STATUS);
    wr(wdf_pkg::ADDR_INT_MASK, 32'h0000_0001);
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0004);
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_001F);
    waitHalt();
    `CHK({haltCoproc_r, failsafeOut_r, irq_r}, 3'h5)
    `CHK({genOut, numOut}, 40'h00_0000_0000)
    `CHK(safeMode_r, 1'b1)
    rd(wdf_pkg::ADDR_STATUS);
    `CHK(d, 32'h0000_0003)
    rd(wdf_pkg::ADDR_INT_STATUS);
    `CHK(d[0], 1'b1)
    `CHK(irq_r, 1'b0)
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0100);
    rd(wdf_pkg::ADDR_STATUS);
    `CHK(d, 32'h0000_0002)
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("full expiry test done");
  endtask : tFull

  task automatic tMask();
    wr(wdf_pkg::ADDR_INT_MASK, 32'h0000_0002);
    wr(wdf_pkg::ADDR_KICK, 32'h0000_0000);
    `CHK(irq_r, 1'b1)
    rd(wdf_pkg::ADDR_INT_MASK);
    `CHK(d, 32'h0000_0002)
    rd(wdf_pkg::ADDR_INT_STATUS);
    `CHK(d, 32'h0000_0002)
    `CHK(irq_r, 1'b0)
    $display("mask test done");
  endtask : tMask

  // A reset in mid-run must drop a running trip and bring the pin low again.
  task automatic tRestart();
    wr(wdf_pkg::ADDR_RELOAD, 32'h0000_0002);
    wr(wdf_pkg::ADDR_CTRL, 32'h0000_0017);
    waitHalt();
    `CHK({failsafeOut_r, haltCoproc_r}, 2'h3)
    `CHK({genOut, numOut}, 40'h00_0000_0000)
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    `CHK({failsafeOut_r, haltMain_r, haltCoproc_r, irq_r}, 4'h0)
    rd(wdf_pkg::ADDR_STATUS);
    `CHK(d, 32'h0000_0000)
    `CHK(failsafeOut_r, 1'b0)
    $display("restart test done");
  endtask : tRestart

  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    genIn = 32'hA5C3_5A3C;
    numIn = 8'h96;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(negedge ref_clk);
    tReset();
    tStandby();
    tKick();
    tSelect();
    tFull();
    tMask();
    tRestart();
    test_done();
  end
endmodule : test_watchdog_failsafe

// ### tb/wdf_safe_equip.sv
// Model of the external equipment that moves to a safe point when the fail-safe pin is low.
`timescale 1ns/100ps
module wdf_safe_equip (
  // Clock
  input wire logic ref_clk,
  // Fail-safe level from the block
  input wire logic failsafeOut,
  // Equipment state
  output logic safeMode_r
);
  always_ff @(posedge ref_clk) begin
    safeMode_r <= !failsafeOut;
  end
endmodule : wdf_safe_equip

// ### tb/wdf_watchdog_sva.sv
// Checker with concurrent assertions on the ports of the watchdog fail-safe block.
`timescale 1ns/100ps
module wdf_watchdog_sva #(
  parameter int GEN_WIDTH = 32,
  parameter int NUM_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port and interrupt
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic irq_r,
  // Channels
  input wire logic [GEN_WIDTH-1:0] generalDigitalChannelsIn,
  input wire logic [GEN_WIDTH-1:0] generalDigitalChannels_r,
  input wire logic [NUM_WIDTH-1:0] numberedOutputChannels_r,
  // Actions
  input wire logic failsafeOut_r,
  input wire logic haltMain_r,
  input wire logic haltCoproc_r
);
  // Shadows of the control and mask registers, kept from the writes seen on the port.
  logic [5:0] ctrlSh_r;
  logic [5:0] ctrlSh_nxt;
  logic [1:0] maskSh_r;
  logic [1:0] maskSh_nxt;

  always_comb begin
    ctrlSh_nxt = ctrlSh_r;
    maskSh_nxt = maskSh_r;
    if (regWr && regAddr == wdf_pkg::ADDR_CTRL) ctrlSh_nxt = regWrData[5:0];
    if (regWr && regAddr == wdf_pkg::ADDR_INT_MASK) maskSh_nxt = regWrData[1:0];
  end

  always_ff @(posedge ref_clk) begin
    ctrlSh_r <= rst ? 6'h00 : ctrlSh_nxt;
    maskSh_r <= rst ? 2'h0 : maskSh_nxt;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_reset_pin_low: assert property ($past(rst) |-> !failsafeOut_r && !haltMain_r)
    else $error("fail-safe pin or halt high after reset");
  chk_standby_level: assert property (!ctrlSh_r[0] |-> failsafeOut_r == ctrlSh_r[5])
    else $error("disabled fail-safe pin differs from standby level");
  chk_main_halt_sel: assert property ($rose(haltMain_r) |-> $past(ctrlSh_r[1]) && $past(ctrlSh_r[0]))
    else $error("main halt without selection");
  chk_coproc_halt_sel: assert property ($rose(haltCoproc_r) |-> $past(ctrlSh_r[2]) && $past(ctrlSh_r[0]))
    else $error("coprocessor halt without selection");
  // Only a fall while enabled on both sides can be an expiry; disabling moves the pin legally.
  chk_pin_low_sel: assert property ($fell(failsafeOut_r) && ctrlSh_r[0] && $past(ctrlSh_r[0]) |-> $past(ctrlSh_r[3]))
    else $error("fail-safe pin forced low without selection");
  chk_outputs_forced: assert property (!$past(rst) && !$past(rst, 2) &&
    generalDigitalChannels_r != $past(generalDigitalChannelsIn) |->
    ~|generalDigitalChannels_r && ~|numberedOutputChannels_r)
    else $error("channels neither passed through nor forced low");
  chk_halt_until_init: assert property ($fell(haltMain_r) && !$past(rst) |->
    $past(regWr && regAddr == wdf_pkg::ADDR_RELOAD))
    else $error("halt released without initialisation");
  chk_irq_masked: assert property (irq_r |-> maskSh_r != 2'h0 || $past(maskSh_r) != 2'h0)
    else $error("interrupt high with all events masked");
endmodule : wdf_watchdog_sva

bind wdf_watchdog wdf_watchdog_sva #(.GEN_WIDTH(GEN_WIDTH), .NUM_WIDTH(NUM_WIDTH)) i_wdf_watchdog_sva (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .irq_r(irq_r),
  .generalDigitalChannelsIn(generalDigitalChannelsIn), .generalDigitalChannels_r(generalDigitalChannels_r),
  .numberedOutputChannels_r(numberedOutputChannels_r), .failsafeOut_r(failsafeOut_r),
  .haltMain_r(haltMain_r), .haltCoproc_r(haltCoproc_r));
